/* dv/acqd_far_model.sv */
// Purpose: digitizer source and acquisition memory for the decimator
// Assumes: one sample per cycle, numbered from the cycle after trigger
// Notes: interval n of two samples carries n then its inverse
`timescale 1ns/1ns
`default_nettype none
module acqd_far_model (
  input wire logic clk_i,
  input wire logic trig_i,
  output logic [7:0] sample_o,
  output logic sample_valid_o,
  input wire logic [15:0] pt_data_i,
  input wire logic pt_valid_i,
  input wire logic [28:0] pt_addr_i
);
  logic [8:0] k = 9'h000; // sample index since trigger
  logic [15:0] mem [0:1023]; // stored record points
  int n_pts = 0; // points stored, cleared by the bench
  // digitizer never pauses
  assign sample_valid_o = 1'b1;
  // even sample n, odd sample inverse of n
  assign sample_o = k[0] ? ~k[8:1] : k[8:1];
  // index realigned by the trigger
  always @(posedge clk_i) begin
    if (trig_i) begin
      k <= 9'h000;
    end else begin
      k <= k + 9'h001;
    end
  end
  // memory side takes every stored point
  always @(posedge clk_i) begin
    if (pt_valid_i) begin
      mem[pt_addr_i[9:0]] <= pt_data_i;
      n_pts <= n_pts + 1;
    end
  end
endmodule
`default_nettype wire

/* dv/tb.sv */
// Purpose: register and record tests of the acquisition decimator
// Assumes: model pattern gives interval n the samples n and ~n
// Notes: records use 1000 points and two samples per interval
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk_i, srst_i, wr_i, rd_i, trig_i, full_variant_i; // drives
  logic [3:0] addr_i; // register index
  logic [31:0] wdata_i, rdata_o, d; // bus data
  logic [7:0] sample_i; // sample from model
  logic sample_valid_i; // sample qualifier
  logic [15:0] pt_data_o; // point value
  logic [28:0] pt_addr_o; // point index
  logic [16:0] pt_seg_o; // segment index
  logic pt_valid_o, busy_o, seg_active_o; // status outputs
  logic [2:0] m [4]; // modes under test
  logic [15:0] e6 [4]; // expected point 6
  logic [15:0] e7 [4]; // expected point 7
  int n_errors = 0;
  int n_checks = 0;
  acqd_top dut (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sample_i(sample_i), .sample_valid_i(sample_valid_i), .trig_i(trig_i),
    .full_variant_i(full_variant_i), .pt_data_o(pt_data_o),
    .pt_valid_o(pt_valid_o), .pt_addr_o(pt_addr_o), .pt_seg_o(pt_seg_o),
    .busy_o(busy_o), .seg_active_o(seg_active_o));
  acqd_far_model far (.clk_i(clk_i), .trig_i(trig_i), .sample_o(sample_i),
    .sample_valid_o(sample_valid_i), .pt_data_i(pt_data_o),
    .pt_valid_i(pt_valid_o), .pt_addr_i(pt_addr_o));
  // compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle write strobe
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // settle, strobe, take data in the following cycle
  task rd(input logic [3:0] a);
    repeat (2) @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // trigger one record and wait for its end
  task run;
    int i;
    far.n_pts = 0;
    @(posedge clk_i);
    trig_i <= 1'b1;
    @(posedge clk_i);
    trig_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (i = 0; i < 6000 && busy_o !== 1'b0; i++) begin
      @(posedge clk_i);
      #1;
    end
    // let the last pair reach the memory model
    repeat (2) @(posedge clk_i);
    #1;
    if (busy_o !== 1'b0) begin
      n_errors++;
    end
  endtask
  // verdict and end of run
  task stop_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // free-running clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // watchdog well beyond the expected run
  initial begin
    #600000;
    n_errors++;
    stop_test;
  end
  // main sequence
  initial begin
    {wr_i, rd_i, trig_i, full_variant_i} = 4'h0;
    addr_i = 4'h0;
    wdata_i = 32'h0;
    srst_i = 1'b1;
    m = '{acqd_pkg::MODE_SAMPLE, acqd_pkg::MODE_PEAK, acqd_pkg::MODE_HIRES,
      acqd_pkg::MODE_ENV};
    e6 = '{16'h0006, 16'h0003, 16'h03fc, 16'h0003};
    e7 = '{16'h0007, 16'h00fc, 16'h03fc, 16'h00fc};
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    // reset values of writable words 1 to 5, unmapped read zero
    for (int a = 1; a < 6; a++) begin
      rd(a[3:0]);
      check(d, 32'h1);
    end
    rd(4'hf);
    check(d, 32'h0);
    // average count limited to 2..512
    wr(acqd_pkg::REG_AVG, 32'h0);
    rd(acqd_pkg::REG_AVG);
    check(d, 32'h1);
    wr(acqd_pkg::REG_AVG, 32'hf);
    rd(acqd_pkg::REG_AVG);
    check(d, 32'h9);
    // envelope count limited, zero kept as unlimited
    wr(acqd_pkg::REG_ENV, 32'h7d0);
    rd(acqd_pkg::REG_ENV);
    check(d, 32'h3e8);
    wr(acqd_pkg::REG_ENV, 32'h0);
    rd(acqd_pkg::REG_ENV);
    check(d, 32'h0);
    // longest record per variant and mode
    wr(acqd_pkg::REG_RECLEN, 32'h7);
    rd(acqd_pkg::REG_STATUS);
    check(d[4:2], 32'h6);
    @(posedge clk_i);
    full_variant_i <= 1'b1;
    rd(acqd_pkg::REG_STATUS);
    check(d[4:2], 32'h7);
    wr(acqd_pkg::REG_CTRL, 32'h1);
    rd(acqd_pkg::REG_STATUS);
    check(d[4:2], 32'h6);
    // segmentation blocked by analyzer or bus decode
    wr(acqd_pkg::REG_CTRL, 32'h18);
    rd(acqd_pkg::REG_STATUS);
    check({d[1], seg_active_o}, 32'h0);
    wr(acqd_pkg::REG_CTRL, 32'h28);
    rd(acqd_pkg::REG_STATUS);
    check({d[1], seg_active_o}, 32'h0);
    wr(acqd_pkg::REG_CTRL, 32'h08);
    rd(acqd_pkg::REG_STATUS);
    check({d[1], seg_active_o}, 32'h3);
    // records of 1000 points in each reducing mode
    wr(acqd_pkg::REG_ENV, 32'h1);
    wr(acqd_pkg::REG_RECLEN, 32'h0);
    for (int j = 0; j < 4; j++) begin
      wr(acqd_pkg::REG_CTRL, {29'h0, m[j]});
      run;
      check(32'(far.n_pts), 32'd1000);
      check({16'h0, far.mem[6]}, {16'h0, e6[j]});
      check({16'h0, far.mem[7]}, {16'h0, e7[j]});
    end
    // two-acquisition average: nothing stored until the second record
    wr(acqd_pkg::REG_AVG, 32'h1);
    wr(acqd_pkg::REG_CTRL, {29'h0, acqd_pkg::MODE_AVG});
    run;
    check(32'(far.n_pts), 32'd0);
    rd(acqd_pkg::REG_ACQCNT);
    check(d, 32'h1);
    run;
    check(32'(far.n_pts), 32'd1000);
    check({16'h0, far.mem[6]}, 32'h6);
    check({16'h0, far.mem[300]}, 32'h2c);
    rd(acqd_pkg::REG_ACQCNT);
    check(d, 32'h0);
    // segmented sample records step the segment index
    wr(acqd_pkg::REG_CTRL, 32'h8);
    wr(acqd_pkg::REG_SEGCNT, 32'h4);
    run;
    check({15'h0, pt_seg_o}, 32'h0);
    run;
    check({15'h0, pt_seg_o}, 32'h1);
    rd(acqd_pkg::REG_SEGIDX);
    check(d, 32'h2);
    stop_test;
  end
endmodule
`default_nettype wire

/* src/acqd_pkg.sv */
// Purpose: constants, register map and helpers for the acquisition decimator
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: register offsets are word indices on the plain register port
//
// What this block does
// - sample mode keeps one sample per interval
// - peak mode emits interval min then max
// - average mode means one sample across acquisitions for the first 1024 intervals
// - average count is power of two, 2..512
// - high-res averages interval samples to 11 bits
// - envelope keeps per-point min/max across acquisitions for the first 1024 intervals
// - envelope count 1..1000 or unlimited
// - record length sets points per acquisition
// - maximum record 500M full, 200M economy
// - full variant allows 500M only in sample
// - segments of record length, 131072 at 1k
// - segmentation off while analyzer or bus on
package acqd_pkg;
  // acquisition modes
  localparam logic [2:0] MODE_SAMPLE = 3'h0;
  localparam logic [2:0] MODE_PEAK = 3'h1;
  localparam logic [2:0] MODE_AVG = 3'h2;
  localparam logic [2:0] MODE_HIRES = 3'h3;
  localparam logic [2:0] MODE_ENV = 3'h4;
  // register word offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_AVG = 4'h1;
  localparam logic [3:0] REG_ENV = 4'h2;
  localparam logic [3:0] REG_RECLEN = 4'h3;
  localparam logic [3:0] REG_IVL = 4'h4;
  localparam logic [3:0] REG_SEGCNT = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  localparam logic [3:0] REG_ACQCNT = 4'h7;
  localparam logic [3:0] REG_SEGIDX = 4'h8;
  // control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SEG_EN = 3;
  localparam int CTRL_LA_EN = 4;
  localparam int CTRL_BUS_EN = 5;
  // reset values
  localparam logic [3:0] AVG_LOG2_RST = 4'h1;
  localparam logic [10:0] ENV_CNT_RST = 11'h001;
  localparam logic [2:0] RECL_RST = 3'h1;
  localparam logic [3:0] IVL_RST = 4'h1;
  localparam logic [17:0] SEG_REQ_RST = 18'h00001;
  // limits
  localparam logic [3:0] AVG_LOG2_MIN = 4'h1;
  localparam logic [3:0] AVG_LOG2_MAX = 4'h9;
  localparam logic [10:0] ENV_CNT_MAX = 11'h3e8;
  localparam logic [2:0] RECL_CODE_200M = 3'h6;
  localparam logic [2:0] RECL_CODE_500M = 3'h7;
  localparam logic [17:0] SEG_MAX_1K = 18'h20000;
  localparam int ACC_DEPTH = 1024;
  localparam int ACC_AW = 10;

  // record length code to stored points
  function automatic logic [28:0] recl_points(input logic [2:0] code);
    case (code)
      3'h0: recl_points = 29'd1000;
      3'h1: recl_points = 29'd10000;
      3'h2: recl_points = 29'd100000;
      3'h3: recl_points = 29'd1000000;
      3'h4: recl_points = 29'd10000000;
      3'h5: recl_points = 29'd100000000;
      3'h6: recl_points = 29'd200000000;
      default: recl_points = 29'd500000000;
    endcase
  endfunction

  // most segments that fit for a record length code
  function automatic logic [17:0] seg_limit(input logic [2:0] code);
    case (code)
      3'h0: seg_limit = SEG_MAX_1K;
      3'h1: seg_limit = 18'd13107;
      3'h2: seg_limit = 18'd1310;
      3'h3: seg_limit = 18'd131;
      3'h4: seg_limit = 18'd13;
      default: seg_limit = 18'd1;
    endcase
  endfunction
endpackage

/* src/acqd_pt_if.sv */
// Purpose: carries one reduced interval from reducer to core
// Assumes: single clock domain
// Notes: valid is a one-cycle pulse per finished interval
`timescale 1ns/1ns
`default_nettype none
interface acqd_pt_if;
  logic valid; // interval finished
  logic [7:0] first; // first sample of interval
  logic [7:0] min_v; // smallest sample
  logic [7:0] max_v; // largest sample
  logic [10:0] avg11; // interval mean, 11 bits
  modport src(output valid, first, min_v, max_v, avg11);
  modport dst(input valid, first, min_v, max_v, avg11);
endinterface
`default_nettype wire

/* src/acqd_reducer.sv */
// Purpose: reduces 2^n raw samples per interval to first, min, max, mean
// Assumes: samples arrive with sample_valid_i, at most one per cycle
// Notes: restart_i realigns the interval to the next sample
`timescale 1ns/1ns
`default_nettype none
module acqd_reducer (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [7:0] sample_i,
  input wire logic sample_valid_i,
  input wire logic restart_i,
  input wire logic [3:0] ivl_log2_i,
  acqd_pt_if.src pt
);
  logic [15:0] cnt; // sample position in interval
  logic [7:0] mn; // running minimum
  logic [7:0] mx; // running maximum
  logic [7:0] fst; // first sample held
  logic [23:0] sum; // running sum
  logic last; // this sample closes the interval
  logic [7:0] next_mn;
  logic [7:0] next_mx;
  logic [23:0] next_sum;
  logic [26:0] scaled; // sum times 8 before divide

  // combinational running values including this sample
  always_comb begin
    last = (cnt == ((16'h0001 << ivl_log2_i) - 16'h0001));
    next_mn = (cnt == 16'h0000 || sample_i < mn) ? sample_i : mn;
    next_mx = (cnt == 16'h0000 || sample_i > mx) ? sample_i : mx;
    next_sum = (cnt == 16'h0000) ? {16'h0000, sample_i}
                                 : sum + {16'h0000, sample_i};
    scaled = {next_sum, 3'b000} >> ivl_log2_i;
  end

  // interval sample counter
  always_ff @(posedge clk_i) begin
    if (srst_i || restart_i) begin
      cnt <= 16'h0000;
    end else if (sample_valid_i) begin
      cnt <= last ? 16'h0000 : cnt + 16'h0001;
    end
  end

  // running statistics
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mn <= 8'h00;
      mx <= 8'h00;
      fst <= 8'h00;
      sum <= 24'h000000;
    end else if (sample_valid_i) begin
      mn <= next_mn;
      mx <= next_mx;
      sum <= next_sum;
      if (cnt == 16'h0000) begin
        fst <= sample_i;
      end
    end
  end

  // registered interval result
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pt.valid <= 1'b0;
      pt.first <= 8'h00;
      pt.min_v <= 8'h00;
      pt.max_v <= 8'h00;
      pt.avg11 <= 11'h000;
    end else begin
      pt.valid <= sample_valid_i && last && !restart_i;
      pt.first <= (cnt == 16'h0000) ? sample_i : fst;
      pt.min_v <= next_mn;
      pt.max_v <= next_mx;
      pt.avg11 <= scaled[10:0];
    end
  end

  // min never above max on a finished interval
  chk_red_minmax: assert property (@(posedge clk_i) disable iff (srst_i)
    pt.valid |-> pt.min_v <= pt.max_v)
    else $error("interval min above max");
endmodule
`default_nettype wire

/* src/acqd_top.sv */
// Purpose: acquisition decimator core with registers and record control
// Assumes: trig_i starts a record while idle; inputs synchronous to clk_i
// Notes: accumulation memories hold the first 1024 interval positions
`timescale 1ns/1ns
`default_nettype none
module acqd_top (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [7:0] sample_i,
  input wire logic sample_valid_i,
  input wire logic trig_i,
  input wire logic full_variant_i,
  output logic [15:0] pt_data_o,
  output logic pt_valid_o,
  output logic [28:0] pt_addr_o,
  output logic [16:0] pt_seg_o,
  output logic busy_o,
  output logic seg_active_o
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } acqd_state_e;

  acqd_pt_if pt();
  acqd_state_e state; // record state

  // configuration registers
  logic [2:0] mode;
  logic seg_en;
  logic la_en;
  logic bus_en;
  logic [3:0] avg_log2;
  logic [10:0] env_cnt; // zero means unlimited
  logic [2:0] recl_code;
  logic [3:0] ivl_log2;
  logic [17:0] seg_req;
  logic cfg_clear; // pulse after a mode, average, envelope or record length change

  // record state
  logic [28:0] pcnt; // stored points this record
  logic [28:0] iidx; // interval index this record
  logic [15:0] acq_cnt; // acquisitions accumulated
  logic [16:0] seg_idx;
  logic pend; // second point of a pair waiting
  logic [15:0] pend_data;

  // accumulation memories
  logic [16:0] acc_mem [0:acqd_pkg::ACC_DEPTH-1];
  logic [7:0] emin_mem [0:acqd_pkg::ACC_DEPTH-1];
  logic [7:0] emax_mem [0:acqd_pkg::ACC_DEPTH-1];

  // derived values
  logic [2:0] cap_code;
  logic [2:0] eff_code;
  logic [28:0] rec_len;
  logic seg_on;
  logic [17:0] seg_total;
  logic [3:0] ivl_eff;
  logic [28:0] ppi; // points per interval
  logic [acqd_pkg::ACC_AW-1:0] idx;
  logic in_acc;
  logic first_acq;
  logic last_avg;
  logic rec_end;
  logic take; // an interval is processed now
  logic [16:0] avg_sum;
  logic [7:0] env_min;
  logic [7:0] env_max;
  logic [15:0] next_acq;
  logic [2:0] next_mode;
  logic [3:0] next_avg;
  logic [10:0] next_env;

  // record length cap per variant and mode
  always_comb begin
    cap_code = (full_variant_i && mode == acqd_pkg::MODE_SAMPLE)
             ? acqd_pkg::RECL_CODE_500M : acqd_pkg::RECL_CODE_200M;
    eff_code = (recl_code > cap_code) ? cap_code : recl_code;
    rec_len = acqd_pkg::recl_points(eff_code);
    seg_on = seg_en && !la_en && !bus_en;
    seg_total = (seg_req > acqd_pkg::seg_limit(eff_code))
              ? acqd_pkg::seg_limit(eff_code) : seg_req;
    if (seg_total == 18'h00000) begin
      seg_total = 18'h00001;
    end
    ivl_eff = ((mode == acqd_pkg::MODE_PEAK || mode == acqd_pkg::MODE_ENV)
               && ivl_log2 == 4'h0) ? 4'h1 : ivl_log2;
    ppi = (mode == acqd_pkg::MODE_PEAK || mode == acqd_pkg::MODE_ENV)
        ? 29'h2 : 29'h1;
  end

  // per-interval decisions
  always_comb begin
    idx = iidx[acqd_pkg::ACC_AW-1:0];
    in_acc = (iidx < 29'(acqd_pkg::ACC_DEPTH));
    first_acq = (acq_cnt == 16'h0000);
    last_avg = (acq_cnt == ((16'h0001 << avg_log2) - 16'h0001));
    take = (state == ST_RUN) && pt.valid && !cfg_clear;
    rec_end = (pcnt + ppi >= rec_len);
    avg_sum = first_acq ? {9'h000, pt.first}
                        : acc_mem[idx] + {9'h000, pt.first};
    env_min = (first_acq || pt.min_v < emin_mem[idx])
            ? pt.min_v : emin_mem[idx];
    env_max = (first_acq || pt.max_v > emax_mem[idx])
            ? pt.max_v : emax_mem[idx];
    case (mode)
      acqd_pkg::MODE_AVG: next_acq = last_avg ? 16'h0000
                                              : acq_cnt + 16'h0001;
      acqd_pkg::MODE_ENV: begin
        if (env_cnt != 11'h000 && acq_cnt + 16'h0001 >= {5'h00, env_cnt}) begin
          next_acq = 16'h0000;
        end else if (acq_cnt == 16'hffff) begin
          next_acq = acq_cnt; // unlimited holds at its maximum
        end else begin
          next_acq = acq_cnt + 16'h0001;
        end
      end
      default: next_acq = 16'h0000;
    endcase
  end

  // clamped write values
  always_comb begin
    next_mode = (wdata_i[2:0] > acqd_pkg::MODE_ENV)
              ? acqd_pkg::MODE_SAMPLE : wdata_i[2:0];
    if (wdata_i[3:0] < acqd_pkg::AVG_LOG2_MIN) begin
      next_avg = acqd_pkg::AVG_LOG2_MIN;
    end else if (wdata_i[3:0] > acqd_pkg::AVG_LOG2_MAX) begin
      next_avg = acqd_pkg::AVG_LOG2_MAX;
    end else begin
      next_avg = wdata_i[3:0];
    end
    next_env = (wdata_i[10:0] > acqd_pkg::ENV_CNT_MAX)
             ? acqd_pkg::ENV_CNT_MAX : wdata_i[10:0];
  end

  // register writes and change detect
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode <= acqd_pkg::MODE_SAMPLE;
      seg_en <= 1'b0;
      la_en <= 1'b0;
      bus_en <= 1'b0;
      avg_log2 <= acqd_pkg::AVG_LOG2_RST;
      env_cnt <= acqd_pkg::ENV_CNT_RST;
      recl_code <= acqd_pkg::RECL_RST;
      ivl_log2 <= acqd_pkg::IVL_RST;
      seg_req <= acqd_pkg::SEG_REQ_RST;
      cfg_clear <= 1'b0;
    end else begin
      cfg_clear <= 1'b0;
      if (wr_i) begin
        case (addr_i)
          acqd_pkg::REG_CTRL: begin
            mode <= next_mode;
            seg_en <= wdata_i[acqd_pkg::CTRL_SEG_EN];
            la_en <= wdata_i[acqd_pkg::CTRL_LA_EN];
            bus_en <= wdata_i[acqd_pkg::CTRL_BUS_EN];
            cfg_clear <= (next_mode != mode);
          end
          acqd_pkg::REG_AVG: begin
            avg_log2 <= next_avg;
            cfg_clear <= (next_avg != avg_log2);
          end
          acqd_pkg::REG_ENV: begin
            env_cnt <= next_env;
            cfg_clear <= (next_env != env_cnt);
          end
          acqd_pkg::REG_RECLEN: begin
            recl_code <= wdata_i[2:0];
            cfg_clear <= (wdata_i[2:0] != recl_code);
          end
          acqd_pkg::REG_IVL: ivl_log2 <= wdata_i[3:0];
          acqd_pkg::REG_SEGCNT: seg_req <= wdata_i[17:0];
          default: ; // read-only or unmapped
        endcase
      end
    end
  end

  // register reads, data one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      case (addr_i)
        acqd_pkg::REG_CTRL: rdata_o <= {26'h0, bus_en, la_en, seg_en, mode};
        acqd_pkg::REG_AVG: rdata_o <= {28'h0, avg_log2};
        acqd_pkg::REG_ENV: rdata_o <= {21'h0, env_cnt};
        acqd_pkg::REG_RECLEN: rdata_o <= {29'h0, recl_code};
        acqd_pkg::REG_IVL: rdata_o <= {28'h0, ivl_log2};
        acqd_pkg::REG_SEGCNT: rdata_o <= {14'h0, seg_req};
        acqd_pkg::REG_STATUS: rdata_o <= {9'h0, seg_total, eff_code,
                                          seg_on, state == ST_RUN};
        acqd_pkg::REG_ACQCNT: rdata_o <= {16'h0, acq_cnt};
        acqd_pkg::REG_SEGIDX: rdata_o <= {15'h0, seg_idx};
        default: rdata_o <= 32'h00000000; // unmapped reads zero
      endcase
    end else begin
      rdata_o <= 32'h00000000;
    end
  end

  // interval reducer
  acqd_reducer u_reducer (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .sample_i(sample_i),
    .sample_valid_i(sample_valid_i),
    .restart_i((state == ST_IDLE) && trig_i),
    .ivl_log2_i(ivl_eff),
    .pt(pt)
  );

  // record sequencing, acquisition and segment counters
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= ST_IDLE;
      pcnt <= 29'h0;
      iidx <= 29'h0;
      acq_cnt <= 16'h0000;
      seg_idx <= 17'h00000;
    end else if (cfg_clear) begin
      state <= ST_IDLE;
      acq_cnt <= 16'h0000;
      seg_idx <= 17'h00000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (trig_i) begin
            state <= ST_RUN;
            pcnt <= 29'h0;
            iidx <= 29'h0;
          end
        end
        ST_RUN: begin
          if (pt.valid) begin
            pcnt <= pcnt + ppi;
            iidx <= iidx + 29'h1;
            if (rec_end) begin
              state <= ST_IDLE;
              acq_cnt <= next_acq;
              if (seg_on && {1'b0, seg_idx} + 18'h1 < seg_total) begin
                seg_idx <= seg_idx + 17'h1;
              end else begin
                seg_idx <= 17'h00000;
              end
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // accumulation memories, first acquisition overwrites
  always_ff @(posedge clk_i) begin
    if (take && in_acc) begin
      acc_mem[idx] <= avg_sum;
      emin_mem[idx] <= env_min;
      emax_mem[idx] <= env_max;
    end
  end

  // point output, pairs emit second value next cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pt_valid_o <= 1'b0;
      pt_data_o <= 16'h0000;
      pt_addr_o <= 29'h0;
      pt_seg_o <= 17'h00000;
      pend <= 1'b0;
      pend_data <= 16'h0000;
    end else begin
      pt_valid_o <= 1'b0;
      pend <= 1'b0;
      if (pend) begin
        pt_valid_o <= 1'b1;
        pt_data_o <= pend_data;
        pt_addr_o <= pt_addr_o + 29'h1;
      end else if (take) begin
        pt_addr_o <= pcnt;
        pt_seg_o <= seg_on ? seg_idx : 17'h00000;
        case (mode)
          acqd_pkg::MODE_PEAK: begin
            pt_valid_o <= 1'b1;
            pt_data_o <= {8'h00, pt.min_v};
            pend <= 1'b1;
            pend_data <= {8'h00, pt.max_v};
          end
          acqd_pkg::MODE_AVG: begin
            pt_valid_o <= last_avg;
            pt_data_o <= in_acc ? 16'(avg_sum >> avg_log2)
                                : {8'h00, pt.first};
          end
          acqd_pkg::MODE_HIRES: begin
            pt_valid_o <= 1'b1;
            pt_data_o <= {5'h00, pt.avg11};
          end
          acqd_pkg::MODE_ENV: begin
            pt_valid_o <= 1'b1;
            pt_data_o <= {8'h00, in_acc ? env_min : pt.min_v};
            pend <= 1'b1;
            pend_data <= {8'h00, in_acc ? env_max : pt.max_v};
          end
          default: begin
            pt_valid_o <= 1'b1;
            pt_data_o <= {8'h00, pt.first};
          end
        endcase
      end
    end
  end

  // status outputs
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      busy_o <= 1'b0;
      seg_active_o <= 1'b0;
    end else begin
      busy_o <= (state == ST_RUN);
      seg_active_o <= seg_on;
    end
  end

  chk_sample_one_pt: assert property (@(posedge clk_i) disable iff (srst_i)
    take && mode == acqd_pkg::MODE_SAMPLE |=> pt_valid_o &&
    pt_data_o == {8'h00, $past(pt.first)} ##1 !pt_valid_o)
    else $error("sample mode point wrong");
  chk_peak_pair: assert property (@(posedge clk_i) disable iff (srst_i)
    take && mode == acqd_pkg::MODE_PEAK |=> pt_valid_o ##1
    (pt_valid_o && pt_data_o >= $past(pt_data_o)))
    else $error("peak pair missing or out of order");
  chk_avg_hold: assert property (@(posedge clk_i) disable iff (srst_i)
    take && mode == acqd_pkg::MODE_AVG && !last_avg |=> !pt_valid_o)
    else $error("average emitted before last acquisition");
  chk_avg_range: assert property (@(posedge clk_i) disable iff (srst_i)
    avg_log2 >= 4'h1 && avg_log2 <= 4'h9)
    else $error("average count out of range");
  chk_hires_width: assert property (@(posedge clk_i) disable iff (srst_i)
    pt_valid_o && mode == acqd_pkg::MODE_HIRES |-> pt_data_o[15:11] == 5'h00)
    else $error("high-res point wider than 11 bits");
  chk_env_limit: assert property (@(posedge clk_i) disable iff (srst_i)
    env_cnt <= 11'h3e8 && (mode != acqd_pkg::MODE_ENV || env_cnt == 11'h0 ||
    cfg_clear || acq_cnt < {5'h00, env_cnt}))
    else $error("envelope count exceeded");
  chk_env_order: assert property (@(posedge clk_i) disable iff (srst_i)
    take && mode == acqd_pkg::MODE_ENV |=> pt_valid_o ##1
    (pt_valid_o && pt_data_o >= $past(pt_data_o)))
    else $error("envelope min above max");
  chk_rec_len: assert property (@(posedge clk_i) disable iff (srst_i)
    state == ST_RUN |-> pcnt < rec_len)
    else $error("record ran past its length");
  chk_rec_cap: assert property (@(posedge clk_i) disable iff (srst_i)
    (mode != acqd_pkg::MODE_SAMPLE || !full_variant_i) |->
    rec_len <= 29'd200000000)
    else $error("record length above 200M");
  chk_seg_bound: assert property (@(posedge clk_i) disable iff (srst_i)
    {1'b0, seg_idx} < seg_total && seg_total <= 18'h20000)
    else $error("segment index out of range");
  chk_seg_block: assert property (@(posedge clk_i) disable iff (srst_i)
    (la_en || bus_en) |=> !seg_active_o)
    else $error("segmentation active with analyzer or bus");
  chk_cfg_clear: assert property (@(posedge clk_i) disable iff (srst_i)
    cfg_clear |=> acq_cnt == 16'h0000 && state == ST_IDLE)
    else $error("config change did not clear accumulation");
endmodule
`default_nettype wire
